// ==== cpu_core_model.sv ====
// CPU core model: accepts on command, holds the disable bit.
// Assumes take, set_i and clr_i change after a rising edge.
module cpu_core_model
    import intc_mask_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Testbench control
    input wire logic take,
    input wire logic set_i,
    input wire logic clr_i,
    // Controller side
    input wire cpu_request_type cpu_request,
    input wire logic set_interrupt_disable,
    output cpu_accept_type cpu_accept,
    output logic interrupt_disable
);
    // Accept only on command, so pending requests stay visible
    always_ff @(posedge aclk) begin
        cpu_accept.accept <= aresetn && take && (cpu_request.nmi || (cpu_request.request && !interrupt_disable));
        cpu_accept.vector <= cpu_request.vector;
    end
    // Disable bit; the controller can only set it
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_i) begin
            interrupt_disable <= 1'b0;
        end else if (set_i || set_interrupt_disable) begin
            interrupt_disable <= 1'b1;
        end
    end
endmodule : cpu_core_model

// ==== intc_mask_level.sv ====
// Interrupt mask levels: priority fields, global mask, pin sources, arbitration.
// Assumes pins synchronous to aclk; peripheral requests come already gated.
//
// Function
// - Five priority registers hold 2-bit level fields: four each, two in the fifth.
// - Field 00 is level 0, 01 level 1, 1x level 2.
// - Low four bits of the fifth priority register are reserved.
// - Nonmaskable source ignores level masking.
// - Global mask bits 7 to 2 always read as one.
// - Global mask 1x blocks levels 0-1, 01 blocks level 0, 00 accepts all.
// - Fourteen external inputs: nonmaskable, eight wake, four request, event counter.
// - Nonmaskable request is highest and ignores the interrupt-disable bit.
// - A bit selects rising or falling edge for the nonmaskable pin.
// - Wake pin edge sets its flag only while port mode selects it.
// - Wake requests are not accepted while wake enable is zero.
// - Interrupt-disable bit set blocks all maskable requests.
// - Accepting wake or event-counter request sets the interrupt-disable bit.
// - Each request pin has its own rising or falling edge select.
// - Selected request pin edge sets its flag only while port mode selects it.
// - Each request pin has its own enable gating acceptance.
// - Event request comes from pin or pwm; rising, falling or both edges.
// - With event enable set, the selected edge sets the event flag.
// - Peripheral requests pass when enabled, leveled by priority registers.
// - Wake flags reset to zero and clear only by writing zero.
// - Equal level: lower vector wins; order is fixed.
module intc_mask_level
    import intc_mask_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // External pins
    input wire logic nmi_pin,
    input wire logic [7:0] wake_pins,
    input wire logic [4:0] ext_request_pins,
    input wire logic event_counter_request_pin,
    input wire logic event_counter_pwm_out,
    // Peripheral request groups
    input wire logic [12:0] periph_requests,
    // CPU side
    input wire logic interrupt_disable,
    input wire cpu_accept_type cpu_accept,
    output cpu_request_type cpu_request,
    output logic set_interrupt_disable
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Upper bit alone decides level 2
    function automatic logic [1:0] level_of(input logic [1:0] field);
        level_of = field[1] ? 2'd2 : {1'b0, field[0]};
    endfunction : level_of

    function automatic logic is_write_hit(input logic [7:0] addr);
        is_write_hit = (addr[1:0] == 2'b00) && (addr <= EVENT_EDGE_OFFSET); // Map is dense and word aligned
    endfunction : is_write_hit

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] priority_level_a;
    logic [7:0] priority_level_b;
    logic [7:0] priority_level_c;
    logic [7:0] priority_level_d;
    logic [7:0] priority_level_e;
    logic [1:0] global_level_mask;
    logic [7:0] edge_select_reg;
    logic [7:0] irq_enable_reg_one;
    logic [4:0] ext_request_flags;
    logic [7:0] wake_request_flags;
    logic [12:0] port_mode;
    logic [2:0] event_edge_select_reg;
    logic nmi_pending;

    // Bus holding state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic do_write;
    logic [7:0] wbyte;

    // Edge detection state
    logic nmi_prev;
    logic [7:0] wake_prev;
    logic [4:0] ext_prev;
    logic event_prev;
    logic nmi_edge;
    logic [7:0] wake_edge;
    logic [4:0] ext_edge;
    logic event_src;
    logic event_edge;

    // Arbitration
    logic [NUM_SRC-1:0] src_pending;
    logic [1:0] src_level [NUM_SRC];
    logic [1:0] threshold;
    logic found;
    logic [5:0] win_vector;
    logic [1:0] win_level;
    logic [39:0] fields;

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // Address and data taken in either order, write fires when both held
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign wbyte = w_data[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_lane0 <= wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= is_write_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Byte lane 0 carries all register data except port mode bits 12:8
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            priority_level_a <= PRIORITY_RESET;
            priority_level_b <= PRIORITY_RESET;
            priority_level_c <= PRIORITY_RESET;
            priority_level_d <= PRIORITY_RESET;
            priority_level_e <= PRIORITY_RESET;
            global_level_mask <= GLOBAL_MASK_RESET;
            edge_select_reg <= BYTE_RESET;
            irq_enable_reg_one <= BYTE_RESET;
            port_mode <= PORT_MODE_RESET;
            event_edge_select_reg <= EVENT_EDGE_RESET;
        end else if (do_write && w_lane0) begin
            unique case (aw_addr)
                PRIORITY_A_OFFSET: priority_level_a <= wbyte;
                PRIORITY_B_OFFSET: priority_level_b <= wbyte;
                PRIORITY_C_OFFSET: priority_level_c <= wbyte;
                PRIORITY_D_OFFSET: priority_level_d <= wbyte;
                PRIORITY_E_OFFSET: priority_level_e <= wbyte & PRIORITY_E_KEEP;
                GLOBAL_MASK_OFFSET: global_level_mask <= wbyte[1:0];
                EDGE_SELECT_OFFSET: edge_select_reg <= wbyte;
                IRQ_ENABLE_OFFSET: irq_enable_reg_one <= wbyte;
                PORT_MODE_OFFSET: port_mode <= w_data[12:0];
                EVENT_EDGE_OFFSET: event_edge_select_reg <= wbyte[2:0];
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Edge detection
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_prev <= 1'b0;
            wake_prev <= 8'h00;
            ext_prev <= 5'h00;
            event_prev <= 1'b0;
        end else begin
            nmi_prev <= nmi_pin;
            wake_prev <= wake_pins;
            ext_prev <= ext_request_pins;
            event_prev <= event_src;
        end
    end

    // Pins taken as synchronous; history resets low, the idle pin level
    always_comb begin
        nmi_edge = edge_select_reg[NMI_EDGE_BIT] ? (nmi_pin && !nmi_prev) : (!nmi_pin && nmi_prev);
        wake_edge = (wake_pins ^ wake_prev) & port_mode[7:0];
        for (int i = 0; i < NUM_EXT; i++) begin
            ext_edge[i] = port_mode[PORT_EXT_LSB + i] &&
                (edge_select_reg[i] ? (ext_request_pins[i] && !ext_prev[i])
                                    : (!ext_request_pins[i] && ext_prev[i]));
        end
        ext_edge[EVENT_FLAG_BIT] = 1'b0;
        // Event counter source and its own edge mode
        event_src = event_edge_select_reg[PWM_ROUTE_BIT] ? event_counter_pwm_out
                                                         : event_counter_request_pin;
        unique case (event_edge_select_reg[1:0])
            EVENT_FALLING: event_edge = !event_src && event_prev;
            EVENT_RISING: event_edge = event_src && !event_prev;
            default: event_edge = event_src ^ event_prev;
        endcase
    end

    // ************************************************************
    // Request flags
    // ************************************************************
    // A new edge wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_request_flags <= 5'h00;
            wake_request_flags <= 8'h00;
        end else begin
            for (int i = 0; i < NUM_EXT; i++) begin
                if (i == EVENT_FLAG_BIT) begin
                    if (event_edge && irq_enable_reg_one[EVENT_ENABLE_BIT]) begin
                        ext_request_flags[i] <= 1'b1;
                    end else if (do_write && w_lane0 && aw_addr == EXT_FLAGS_OFFSET && !wbyte[i]) begin
                        ext_request_flags[i] <= 1'b0;
                    end
                end else if (ext_edge[i]) begin
                    ext_request_flags[i] <= 1'b1;
                end else if (do_write && w_lane0 && aw_addr == EXT_FLAGS_OFFSET && !wbyte[i]) begin
                    ext_request_flags[i] <= 1'b0;
                end
            end
            for (int i = 0; i < NUM_WAKE; i++) begin
                if (wake_edge[i]) begin
                    wake_request_flags[i] <= 1'b1;
                end else if (do_write && w_lane0 && aw_addr == WAKE_FLAGS_OFFSET && !wbyte[i]) begin
                    wake_request_flags[i] <= 1'b0;
                end
            end
        end
    end

    // Nonmaskable request held until the CPU takes its vector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pending <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pending <= 1'b1;
        end else if (cpu_accept.accept && cpu_accept.vector == NMI_VECTOR) begin
            nmi_pending <= 1'b0;
        end
    end

    // ************************************************************
    // Level arbitration
    // ************************************************************
    // Source index i carries vector FIRST_VECTOR + i; flags stay set while blocked
    assign fields = {priority_level_a, priority_level_b, priority_level_c, priority_level_d, priority_level_e};

    always_comb begin
        threshold = global_level_mask[1] ? 2'd2 : {1'b0, global_level_mask[0]};
        for (int i = 0; i < NUM_EXT; i++) begin
            src_pending[i] = ext_request_flags[i] &&
                (i == EVENT_FLAG_BIT ? irq_enable_reg_one[EVENT_ENABLE_BIT] : irq_enable_reg_one[i]);
            src_level[i] = level_of(fields[39 - 2 * (i == 4 ? 3 : i) -: 2]);
        end
        for (int i = 0; i < NUM_WAKE; i++) begin
            src_pending[WAKE_FIRST + i] = wake_request_flags[i] && irq_enable_reg_one[WAKE_ENABLE_BIT];
            src_level[WAKE_FIRST + i] = level_of(fields[39 - 2 * FIELD_OF_WAKE -: 2]);
        end
        for (int g = 0; g < NUM_PERIPH; g++) begin
            src_pending[WAKE_FIRST + NUM_WAKE + g] = periph_requests[g];
            src_level[WAKE_FIRST + NUM_WAKE + g] = level_of(fields[39 - 2 * (FIELD_OF_PERIPH + g) -: 2]);
        end
        // Highest level first, lowest vector within a level
        found = 1'b0;
        win_level = 2'd0;
        win_vector = FIRST_VECTOR;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_pending[i] && src_level[i] >= threshold && !interrupt_disable) begin
                if (!found || src_level[i] > win_level) begin
                    found = 1'b1;
                    win_level = src_level[i];
                    win_vector = FIRST_VECTOR + 6'(i);
                end
            end
        end
    end

    // ************************************************************
    // CPU request and disable-bit update
    // ************************************************************
    // Nonmaskable bypasses threshold and disable bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_request <= '0;
        end else begin
            cpu_request.nmi <= nmi_pending;
            cpu_request.request <= nmi_pending || found;
            cpu_request.vector <= nmi_pending ? NMI_VECTOR : win_vector;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            set_interrupt_disable <= 1'b0;
        end else begin
            set_interrupt_disable <= cpu_accept.accept &&
                (cpu_accept.vector == EVENT_VECTOR ||
                 (cpu_accept.vector >= WAKE_VECTOR_LO && cpu_accept.vector <= WAKE_VECTOR_HI));
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            unique case (araddr)
                PRIORITY_A_OFFSET: rdata <= 32'(priority_level_a);
                PRIORITY_B_OFFSET: rdata <= 32'(priority_level_b);
                PRIORITY_C_OFFSET: rdata <= 32'(priority_level_c);
                PRIORITY_D_OFFSET: rdata <= 32'(priority_level_d);
                PRIORITY_E_OFFSET: rdata <= 32'(priority_level_e);
                GLOBAL_MASK_OFFSET: rdata <= 32'(GLOBAL_MASK_ONES | {6'h00, global_level_mask});
                EDGE_SELECT_OFFSET: rdata <= 32'(edge_select_reg);
                IRQ_ENABLE_OFFSET: rdata <= 32'(irq_enable_reg_one);
                EXT_FLAGS_OFFSET: rdata <= 32'(ext_request_flags);
                WAKE_FLAGS_OFFSET: rdata <= 32'(wake_request_flags);
                PORT_MODE_OFFSET: rdata <= 32'(port_mode);
                EVENT_EDGE_OFFSET: rdata <= 32'(event_edge_select_reg);
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : intc_mask_level

// ==== intc_mask_level_chk.sv ====
// Assertions on the mask-level block's ports.
// Assumes aclk and a synchronous active-low aresetn.
module intc_mask_level_chk
    import intc_mask_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    // CPU side
    input wire logic interrupt_disable,
    input wire cpu_accept_type cpu_accept,
    input wire cpu_request_type cpu_request,
    input wire logic set_interrupt_disable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Nonmaskable vector fixed
    property p_nmi_vec; cpu_request.nmi |-> cpu_request.vector == NMI_VECTOR; endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi request with wrong vector");
    // Disable bit blocks next request
    property p_blocked; $past(interrupt_disable) && !cpu_request.nmi |-> !cpu_request.request; endproperty
    a_blocked: assert property (p_blocked) else $error("maskable request while disabled");
    property p_set_i; cpu_accept.accept && (cpu_accept.vector == EVENT_VECTOR
        || cpu_accept.vector inside {[WAKE_VECTOR_LO:WAKE_VECTOR_HI]}) |=> set_interrupt_disable; endproperty
    a_set_i: assert property (p_set_i) else $error("disable bit not set after accept");
    property p_set_cause; set_interrupt_disable |-> $past(cpu_accept.accept); endproperty
    a_set_cause: assert property (p_set_cause) else $error("disable bit set without accept");
    property p_set_pulse; set_interrupt_disable |=> !set_interrupt_disable; endproperty
    a_set_pulse: assert property (p_set_pulse) else $error("disable pulse too long");
    // Reserved read bits
    property p_ones; arvalid && arready && araddr == GLOBAL_MASK_OFFSET |=> rdata[7:2] == 6'h3F; endproperty
    a_ones: assert property (p_ones) else $error("global mask upper bits not one");
    property p_rsvd; arvalid && arready && araddr == PRIORITY_E_OFFSET |=> rdata[3:0] == 4'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved priority bits not zero");
    property p_resp; bvalid && bready |=> !bvalid; endproperty
    a_resp: assert property (p_resp) else $error("write response repeated");
endmodule : intc_mask_level_chk

bind intc_mask_level intc_mask_level_chk chk (.*);

// ==== intc_mask_level_tb_top.sv ====
// Self-checking bench for the mask-level block.
// Assumes the map and vectors of the package.
module intc_mask_level_tb_top;
    import intc_mask_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1, event_counter_pwm_out = 1'b0;
    logic [12:0] periph_requests = 13'h0000;
    logic nmi_pin = 1'b0, event_counter_request_pin = 1'b0, take = 1'b0, set_i = 1'b0, clr_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, wake_pins = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [4:0] ext_request_pins = 5'h00;
    logic awready, wready, bvalid, arready, rvalid, set_interrupt_disable, interrupt_disable;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    cpu_request_type cpu_request;
    cpu_accept_type cpu_accept;
    int errors = 0, compares = 0;
    // All byte lanes written
    intc_mask_level DUT (.*, .wstrb(4'hF));
    cpu_core_model cpu (.*);
    always #2 aclk = ~aclk;
    task automatic chk(input logic [39:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle();
        repeat (4) @(posedge aclk);
    endtask : idle
    // Both halves offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, resp);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp = RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk({rresp, rdata}, {resp, exp});
    endtask : rd
    task automatic grab();
        take <= 1'b1;
        @(posedge aclk);
        take <= 1'b0;
        idle();
    endtask : grab
    task automatic t_regs();
        periph_requests <= 13'h1000;
        rd(GLOBAL_MASK_OFFSET, 32'h0000_00FC);
        chk(cpu_request, 8'h5F);
        periph_requests <= 13'h0000;
        wr(GLOBAL_MASK_OFFSET, 32'h0000_0001);
        rd(GLOBAL_MASK_OFFSET, 32'h0000_00FD);
        wr(PRIORITY_E_OFFSET, 32'h0000_00FF);
        rd(PRIORITY_E_OFFSET, 32'h0000_00F0);
        wr(PRIORITY_A_OFFSET, 32'h0000_00A5);
        rd(PRIORITY_A_OFFSET, 32'h0000_00A5);
        rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    endtask : t_regs
    task automatic t_pin();
        set_i <= 1'b1;
        wr(EDGE_SELECT_OFFSET, 32'h0000_0081);
        wr(PORT_MODE_OFFSET, 32'h0000_0101);
        ext_request_pins <= 5'h01;
        idle();
        rd(EXT_FLAGS_OFFSET, 32'h0000_0001);
        set_i <= 1'b0;
        clr_i <= 1'b1;
        idle();
        chk(cpu_request.request, 1'b0);
        clr_i <= 1'b0;
        wr(IRQ_ENABLE_OFFSET, 32'h0000_0001);
        idle();
        chk(cpu_request, 8'h46);
        wr(GLOBAL_MASK_OFFSET, 32'h0000_0002);
        wr(PRIORITY_A_OFFSET, 32'h0000_0065);
        idle();
        chk(cpu_request.request, 1'b0);
        wr(PRIORITY_A_OFFSET, 32'h0000_00E5);
        idle();
        chk(cpu_request, 8'h46);
        wr(EXT_FLAGS_OFFSET, 32'h0000_0000);
        ext_request_pins <= 5'h00;
        idle();
        rd(EXT_FLAGS_OFFSET, 32'h0000_0000);
    endtask : t_pin
    task automatic t_wake();
        wr(GLOBAL_MASK_OFFSET, 32'h0000_0000);
        wake_pins <= 8'h01;
        idle();
        rd(WAKE_FLAGS_OFFSET, 32'h0000_0001);
        chk(cpu_request.request, 1'b0);
        wr(IRQ_ENABLE_OFFSET, 32'h0000_0020);
        idle();
        chk(cpu_request, 8'h4B);
        grab();
        chk(interrupt_disable, 1'b1);
        chk(cpu_request.request, 1'b0);
        wr(WAKE_FLAGS_OFFSET, 32'h0000_00FF);
        rd(WAKE_FLAGS_OFFSET, 32'h0000_0001);
        wr(WAKE_FLAGS_OFFSET, 32'h0000_0000);
        wake_pins <= 8'h05;
        idle();
        rd(WAKE_FLAGS_OFFSET, 32'h0000_0000);
    endtask : t_wake
    task automatic t_nmi();
        nmi_pin <= 1'b1;
        idle();
        chk({cpu_request.nmi, cpu_request.vector}, {1'b1, NMI_VECTOR});
        grab();
        chk(cpu_request.nmi, 1'b0);
        wr(EDGE_SELECT_OFFSET, 32'h0000_0001);
        nmi_pin <= 1'b0;
        idle();
        chk(cpu_request.nmi, 1'b1);
        grab();
        nmi_pin <= 1'b1;
        idle();
        chk(cpu_request.nmi, 1'b0);
    endtask : t_nmi
    task automatic t_event();
        clr_i <= 1'b1;
        wr(IRQ_ENABLE_OFFSET, 32'h0000_0004);
        wr(EVENT_EDGE_OFFSET, 32'h0000_0002);
        clr_i <= 1'b0;
        event_counter_request_pin <= 1'b1;
        idle();
        chk(cpu_request, 8'h48);
        wr(EXT_FLAGS_OFFSET, 32'h0000_0000);
        event_counter_request_pin <= 1'b0;
        idle();
        rd(EXT_FLAGS_OFFSET, 32'h0000_0004);
        grab();
        chk(interrupt_disable, 1'b1);
        wr(EXT_FLAGS_OFFSET, 32'h0000_0000);
        event_counter_pwm_out <= 1'b1;
        wr(EVENT_EDGE_OFFSET, 32'h0000_0005);
        rd(EXT_FLAGS_OFFSET, 32'h0000_0004);
    endtask : t_event
    task automatic conclude();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Hang guard
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pin();
        t_wake();
        t_nmi();
        t_event();
        conclude();
    end
endmodule : intc_mask_level_tb_top

// ==== intc_mask_pkg.sv ====
// Constants, register map and carrier types of the interrupt mask-level block.
// Assumes one system clock and a 32-bit AXI4-Lite register bus.
package intc_mask_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] PRIORITY_A_OFFSET = 8'h00;
    localparam logic [7:0] PRIORITY_B_OFFSET = 8'h04;
    localparam logic [7:0] PRIORITY_C_OFFSET = 8'h08;
    localparam logic [7:0] PRIORITY_D_OFFSET = 8'h0C;
    localparam logic [7:0] PRIORITY_E_OFFSET = 8'h10;
    localparam logic [7:0] GLOBAL_MASK_OFFSET = 8'h14;
    localparam logic [7:0] EDGE_SELECT_OFFSET = 8'h18;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h1C;
    localparam logic [7:0] EXT_FLAGS_OFFSET = 8'h20;
    localparam logic [7:0] WAKE_FLAGS_OFFSET = 8'h24;
    localparam logic [7:0] PORT_MODE_OFFSET = 8'h28;
    localparam logic [7:0] EVENT_EDGE_OFFSET = 8'h2C;

    // ************************************************************
    // Reset values and fixed bits
    // ************************************************************
    localparam logic [7:0] PRIORITY_RESET = 8'h00;
    localparam logic [1:0] GLOBAL_MASK_RESET = 2'h0;
    localparam logic [7:0] GLOBAL_MASK_ONES = 8'hFC;
    localparam logic [7:0] PRIORITY_E_KEEP = 8'hF0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [12:0] PORT_MODE_RESET = 13'h0000;
    localparam logic [2:0] EVENT_EDGE_RESET = 3'h0;

    // ************************************************************
    // Field positions
    // ************************************************************
    // Edge select: bits 0,1,3,4 per request pin, bit 7 nonmaskable edge
    localparam int NMI_EDGE_BIT = 7;
    // Enable register: bits 0,1,3,4 request pins, 2 event counter, 5 wake
    localparam int EVENT_ENABLE_BIT = 2;
    localparam int WAKE_ENABLE_BIT = 5;
    // Flags register: bit 2 is the event-counter request flag
    localparam int EVENT_FLAG_BIT = 2;
    // Event edge register: [1:0] edge mode, bit 2 pwm routing
    localparam int PWM_ROUTE_BIT = 2;
    // Port mode register: [7:0] wake pins, [12:8] request pins 0..4
    localparam int PORT_EXT_LSB = 8;

    // ************************************************************
    // Sources and vectors
    // ************************************************************
    localparam int NUM_EXT = 5;
    localparam int NUM_WAKE = 8;
    localparam int NUM_PERIPH = 13;
    localparam int NUM_SRC = NUM_EXT + NUM_WAKE + NUM_PERIPH;
    localparam int WAKE_FIRST = 5;
    localparam int FIELD_OF_WAKE = 4;
    localparam int FIELD_OF_PERIPH = 5;
    localparam logic [5:0] NMI_VECTOR = 6'h03;
    localparam logic [5:0] FIRST_VECTOR = 6'h06;
    localparam logic [5:0] EVENT_VECTOR = 6'h08;
    localparam logic [5:0] WAKE_VECTOR_LO = 6'h0B;
    localparam logic [5:0] WAKE_VECTOR_HI = 6'h12;

    // Event edge modes
    localparam logic [1:0] EVENT_FALLING = 2'h0;
    localparam logic [1:0] EVENT_RISING = 2'h1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Request presented to the CPU
    typedef struct packed {
        logic nmi;
        logic request;
        logic [5:0] vector;
    } cpu_request_type;

    // Acknowledge from the CPU
    typedef struct packed {
        logic accept;
        logic [5:0] vector;
    } cpu_accept_type;

endpackage : intc_mask_pkg
